// File: logic/adcpc_pin_ctrl.sv
// Pin level control of the six channel converter toward its host
`timescale 1ns/100ps
`include "adcpc_defs.svh"
// Behaviour
// RQ1: lane two enabled by its select input
// RQ2: host holds lane one select high
// RQ3: busy high from start to latch
// RQ4: sequential mode pulses busy low per pair
// RQ5: interrupt held until result is read
// RQ6: polarity bit inverts busy/interrupt output
// RQ7: parallel interface only while select low
// RQ8: frame sync falling edge starts frame
// RQ9: data driven only while read low
// RQ10: hardware mode rising edge starts pair three
// RQ11: early fall powers pair three down
// RQ12: software mode start only when sequential
// RQ13: low data bits word mode only
// RQ14: interface select picks parallel or serial
module adcpc_pin_ctrl (
  input  wire logic        core_clk_i,              // 250 MHz core clock
  input  wire logic        rst_i,                   // Synchronous reset, active high
  input  wire logic [7:0]  reg_addr_i,              // Register byte address
  input  wire logic [31:0] reg_wdata_i,             // Register write data
  input  wire logic        reg_wr_i,                // Write strobe
  input  wire logic        reg_rd_i,                // Read strobe
  output logic      [31:0] reg_rdata_o,             // Read data, cycle after strobe
  input  wire logic        interface_select_i,      // Low parallel, high serial
  input  wire logic        pin_or_register_mode_i,  // Low hardware, high software
  input  wire logic        word_mode_n_i,           // Low word mode, high byte mode
  input  wire logic        select_or_frame_sync_i,  // Chip select or frame sync
  input  wire logic        read_n_i,                // Read input, active low
  input  wire logic        start_pair_three_i,      // Pair three convert start
  input  wire logic        conv_start_i,            // Start from the other start pins
  input  wire logic        pair_done_i,             // One pair finished converting
  input  wire logic        all_latched_i,           // All six results latched
  input  wire logic        cclk_tick_i,             // One per conversion clock period
  input  wire logic        data_bit_one_i,          // Bit 1 in, or lane two select
  input  wire logic        data_bit_zero_i,         // Bit 0 in, or lane one select
  input  wire logic [1:0]  result_low_i,            // Low result bits from output reg
  output logic             serial_out_lane_one_en_o,// Lane one driven
  output logic             serial_out_lane_two_en_o,// Lane two driven
  output logic             busy_int_o,              // Busy or interrupt pin
  output logic             par_active_o,            // Parallel interface enabled
  output logic             frame_start_o,           // Pulse, frame transfer begins
  output logic             data_oe_o,               // Parallel data enable
  output logic [1:0]       data_low_o,              // Bits 1 and 0 driven out
  output logic             data_low_oe_o,           // Enable of bits 1 and 0
  output logic             pair_three_start_o,      // Pulse, pair three starts
  output logic             pair_three_pdown_o       // Pair three partial power-down
);

  adcpc_pkg::adcpc_state_t state_q, state_d;   // Conversion tracking
  adcpc_pkg::adcpc_ctrl_t  ctrl_q, ctrl_d;     // Software control bits
  logic        raw_q, raw_d;                   // Active level before polarity
  logic        int_q, int_d;                   // Interrupt pending
  logic        seqlo_q, seqlo_d;               // Sequential low pulse running
  logic        p3busy_q, p3busy_d;             // Pair three converting
  logic        pdown_q, pdown_d;               // Pair three powered down
  logic        start3_prev_q;                  // Last start pin level
  logic        fs_prev_q;                      // Last chip select level
  logic        rd_prev_q;                      // Last read level
  logic [31:0] rdata_d;                        // Next read data
  logic        start3_rise;                    // Start pin rising
  logic        start3_take;                    // Start pin accepted
  logic        frame_fall;                     // Frame sync falling
  logic        result_read;                    // Host fetched a result
  logic        serial;                         // Serial interface chosen
  logic        oe_d;                           // Next parallel data enable

  // Decodes a register address against one offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Edges and mode decode
  always_comb
  begin
    serial      = interface_select_i;
    start3_rise = start_pair_three_i & ~start3_prev_q;
    // Hardware mode always, software mode only when sequential
    start3_take = start3_rise & (~pin_or_register_mode_i | ctrl_q.seq);  // see RQ10 see RQ12
    frame_fall  = serial & fs_prev_q & ~select_or_frame_sync_i;          // see RQ8
    // Parallel read edge counts only with the interface enabled
    result_read = serial ? frame_fall
                         : (~select_or_frame_sync_i & rd_prev_q & ~read_n_i);
    oe_d        = ~serial & ~select_or_frame_sync_i & ~read_n_i;         // see RQ7 see RQ9
  end

  // Conversion, busy and interrupt next state
  always_comb
  begin
    state_d  = state_q;
    seqlo_d  = seqlo_q;
    int_d    = int_q;
    p3busy_d = p3busy_q;
    pdown_d  = pdown_q;
    unique case (state_q)
      adcpc_pkg::ADCPC_IDLE:
      begin
        // New start only once the last one has fully latched
        if (conv_start_i | start3_take)
        begin
          state_d = adcpc_pkg::ADCPC_CONV;
        end
      end
      adcpc_pkg::ADCPC_CONV:
      begin
        if (all_latched_i)
        begin
          state_d = adcpc_pkg::ADCPC_IDLE;
        end
      end
    endcase
    // Low pulse lasts until the next conversion clock tick
    if (seqlo_q & cclk_tick_i)
    begin
      seqlo_d = 1'b0;
    end
    if (ctrl_q.seq & (state_q == adcpc_pkg::ADCPC_CONV) & pair_done_i & ~all_latched_i)
    begin
      seqlo_d = 1'b1;                                                    // see RQ4
    end
    if (state_q == adcpc_pkg::ADCPC_IDLE)
    begin
      seqlo_d = 1'b0;
    end
    // Read clears, a new completion in the same cycle wins
    if (result_read)
    begin
      int_d = 1'b0;
    end
    if ((state_q == adcpc_pkg::ADCPC_CONV) & all_latched_i)
    begin
      int_d = 1'b1;                                                      // see RQ5
    end
    // Pair three tracking and early release of its start pin
    if (p3busy_q & (pair_done_i | all_latched_i))
    begin
      p3busy_d = 1'b0;
    end
    if (p3busy_q & ~start_pair_three_i)
    begin
      pdown_d  = 1'b1;                                                   // see RQ11
      p3busy_d = 1'b0;
    end
    if (start3_take & (state_q == adcpc_pkg::ADCPC_IDLE))
    begin
      p3busy_d = 1'b1;
      pdown_d  = 1'b0;
    end
    // Busy in busy mode, pending flag in interrupt mode
    if (ctrl_q.irq)
    begin
      raw_d = int_d;
    end
    else
    begin
      raw_d = (state_d == adcpc_pkg::ADCPC_CONV) & ~seqlo_d;             // see RQ3
    end
  end

  // Register writes and read data
  always_comb
  begin
    ctrl_d  = ctrl_q;
    rdata_d = `ADCPC_WORD_ZERO;
    if (reg_wr_i & hit(reg_addr_i, `ADCPC_OFS_CTRL))
    begin
      ctrl_d.seq = reg_wdata_i[`ADCPC_BIT_SEQ];
      ctrl_d.irq = reg_wdata_i[`ADCPC_BIT_IRQ];
      ctrl_d.pol = reg_wdata_i[`ADCPC_BIT_POL];
    end
    if (reg_rd_i & hit(reg_addr_i, `ADCPC_OFS_CTRL))
    begin
      rdata_d[`ADCPC_BIT_SEQ] = ctrl_q.seq;
      rdata_d[`ADCPC_BIT_IRQ] = ctrl_q.irq;
      rdata_d[`ADCPC_BIT_POL] = ctrl_q.pol;
    end
    else if (reg_rd_i & hit(reg_addr_i, `ADCPC_OFS_STAT))
    begin
      rdata_d[`ADCPC_ST_CONV]  = (state_q == adcpc_pkg::ADCPC_CONV);
      rdata_d[`ADCPC_ST_RAW]   = raw_q;
      rdata_d[`ADCPC_ST_INT]   = int_q;
      rdata_d[`ADCPC_ST_PDOWN] = pdown_q;
      rdata_d[`ADCPC_ST_SEQLO] = seqlo_q;
    end
    // Unmapped addresses read as zero
  end

  // State registers and registered pins
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_q                  <= adcpc_pkg::ADCPC_IDLE;
      ctrl_q                   <= `ADCPC_CTRL_RST;
      raw_q                    <= 1'b0;
      int_q                    <= 1'b0;
      seqlo_q                  <= 1'b0;
      p3busy_q                 <= 1'b0;
      pdown_q                  <= 1'b0;
      start3_prev_q            <= 1'b0;
      fs_prev_q                <= 1'b1;
      rd_prev_q                <= 1'b1;
      reg_rdata_o              <= `ADCPC_WORD_ZERO;
      serial_out_lane_one_en_o <= 1'b0;
      serial_out_lane_two_en_o <= 1'b0;
      busy_int_o               <= 1'b0;
      par_active_o             <= 1'b0;
      frame_start_o            <= 1'b0;
      data_oe_o                <= 1'b0;
      data_low_o               <= 2'h0;
      data_low_oe_o            <= 1'b0;
      pair_three_start_o       <= 1'b0;
      pair_three_pdown_o       <= 1'b0;
    end
    else
    begin
      state_q                  <= state_d;
      ctrl_q                   <= ctrl_d;
      raw_q                    <= raw_d;
      int_q                    <= int_d;
      seqlo_q                  <= seqlo_d;
      p3busy_q                 <= p3busy_d;
      pdown_q                  <= pdown_d;
      start3_prev_q            <= start_pair_three_i;
      fs_prev_q                <= select_or_frame_sync_i;
      rd_prev_q                <= read_n_i;
      reg_rdata_o              <= rdata_d;
      // Lane one relies on the host holding its select high
      serial_out_lane_one_en_o <= serial & data_bit_zero_i;              // see RQ2
      serial_out_lane_two_en_o <= serial & data_bit_one_i;               // see RQ1
      busy_int_o               <= raw_d ^ ctrl_d.pol;                    // see RQ6
      par_active_o             <= ~serial & ~select_or_frame_sync_i;     // see RQ7 see RQ14
      frame_start_o            <= frame_fall;                            // see RQ8
      data_oe_o                <= oe_d;                                  // see RQ9
      // In byte mode these pins are straps, never driven
      data_low_o               <= result_low_i;
      data_low_oe_o            <= oe_d & ~word_mode_n_i;                 // see RQ13
      pair_three_start_o       <= start3_take & (state_q == adcpc_pkg::ADCPC_IDLE);
      pair_three_pdown_o       <= pdown_d;                               // see RQ11
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Shared step sequences
  sequence s_pair_done_seq;
    ctrl_q.seq && !ctrl_q.irq && !ctrl_q.pol && state_q == adcpc_pkg::ADCPC_CONV
      && pair_done_i && !all_latched_i;
  endsequence
  sequence s_low_until_tick;
    !busy_int_o && !cclk_tick_i;
  endsequence

  property p_lane_two;
    interface_select_i && !data_bit_one_i |=> !serial_out_lane_two_en_o;
  endproperty
  a_lane_two: assert property (p_lane_two) else $error("lane two on while deselected"); // see RQ1

  property p_busy_drop;
    !ctrl_q.irq && !ctrl_q.pol && state_q == adcpc_pkg::ADCPC_CONV && all_latched_i
      |=> !busy_int_o;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy stayed high"); // see RQ3

  property p_seq_pulse;
    s_pair_done_seq |=> s_low_until_tick ##1 !busy_int_o;
  endproperty
  a_seq_pulse: assert property (p_seq_pulse) else $error("sequential pulse wrong"); // see RQ4

  property p_int_hold;
    ctrl_q.irq && int_q && !result_read |=> int_q;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt lost early"); // see RQ5

  property p_pol;
    ctrl_q.pol && ctrl_d.pol && !raw_d |=> busy_int_o;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not inverted"); // see RQ6

  property p_par_ignore;
    !interface_select_i && select_or_frame_sync_i |=> !par_active_o && !data_oe_o;
  endproperty
  a_par_ignore: assert property (p_par_ignore) else $error("parallel active while high"); // see RQ7

  property p_frame;
    interface_select_i && fs_prev_q && !select_or_frame_sync_i |=> frame_start_o;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start missed"); // see RQ8

  property p_rd_oe;
    read_n_i |=> !data_oe_o && !data_low_oe_o;
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("data driven with read high"); // see RQ9

  property p_hw_start;
    !pin_or_register_mode_i && start3_rise && state_q == adcpc_pkg::ADCPC_IDLE
      |=> pair_three_start_o ##1 !pair_three_start_o;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("pair three start missed"); // see RQ10

  property p_pdown;
    p3busy_q && !start_pair_three_i |=> pair_three_pdown_o;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down missed"); // see RQ11

  property p_sw_ignore;
    pin_or_register_mode_i && !ctrl_q.seq |=> !pair_three_start_o;
  endproperty
  a_sw_ignore: assert property (p_sw_ignore) else $error("start taken in software mode"); // see RQ12

  property p_byte;
    word_mode_n_i |=> !data_low_oe_o;
  endproperty
  a_byte: assert property (p_byte) else $error("low bits driven in byte mode"); // see RQ13

endmodule

// File: include/adcpc_defs.svh
// Offsets, bit positions and reset values of the pin control block
`ifndef ADCPC_DEFS_SVH
`define ADCPC_DEFS_SVH
`define ADCPC_OFS_CTRL 8'h00
`define ADCPC_OFS_STAT 8'h04
`define ADCPC_BIT_SEQ  23
`define ADCPC_BIT_IRQ  21
`define ADCPC_BIT_POL  20
`define ADCPC_ST_CONV  0
`define ADCPC_ST_RAW   1
`define ADCPC_ST_INT   2
`define ADCPC_ST_PDOWN 3
`define ADCPC_ST_SEQLO 4
`define ADCPC_CTRL_RST 3'h0
`define ADCPC_WORD_ZERO 32'h00000000
`endif

// File: include/adcpc_pkg.sv
// Types shared by the pin control block
package adcpc_pkg;
  // Conversion tracking state
  typedef enum logic [0:0] {
    ADCPC_IDLE = 1'b0,
    ADCPC_CONV = 1'b1
  } adcpc_state_t;
  // Control bits held by software
  typedef struct packed {
    logic seq;
    logic irq;
    logic pol;
  } adcpc_ctrl_t;
endpackage

// File: sim/adcpc_host_model.sv
// Host side model that drives the shared pins of the converter
`timescale 1ns/100ps
module adcpc_host_model (
  input  wire logic clk_i,      // Core clock
  input  wire logic ser_i,      // Serial interface chosen
  input  wire logic word_i,     // Word mode chosen
  input  wire logic sel_i,      // Frame or chip select wanted
  input  wire logic lane_i,     // Lane two wanted, or data bit
  output logic      fs_o,       // Chip select or frame sync pin
  output logic      bit_one_o,  // Bit one or lane two select
  output logic      bit_zero_o  // Bit zero or lane one select
);
  initial fs_o = 1'b1;
  initial bit_one_o = 1'b0;
  initial bit_zero_o = 1'b0;
  // Pins move just after the edge, one cycle behind the request
  always @(posedge clk_i)
  begin
    fs_o       <= ~sel_i;                      // Idles high, falls per frame
    bit_zero_o <= ser_i | (word_i & ~lane_i);  // Lane one never off
    bit_one_o  <= (ser_i | word_i) & lane_i;   // Parallel byte mode ties low
  end
endmodule

// File: sim/adc_host_pin_control_tb.sv
// Self-checking bench of the converter pin control block
`timescale 1ns/100ps
module adc_host_pin_control_tb;
  typedef struct {int due; int lsb; logic [31:0] v;} adcpc_note_t;
  localparam int L1 = 0, L2 = 1, BZ = 2, PA = 3, FS = 4, OE = 5, DL = 6;
  localparam int LO = 8, P3 = 9, PD = 10, RD = 11;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;  // Clock, reset, strobes
  logic        ser = 1'b0, hws = 1'b0, wrd_n = 1'b0;          // Mode levels
  logic        rd_n = 1'b1, st3 = 1'b0, cnv = 1'b0;           // Read and starts
  logic        pd = 1'b0, al = 1'b0, tck = 1'b0, b;           // Core events
  logic        sel = 1'b0, lane = 1'b0;                       // Host model requests
  logic        fs_w, b1_w, b0_w;                              // Host model pins
  logic [1:0]  rlow = 2'h0;                                   // Low result bits
  logic [7:0]  addr = 8'h00;                                  // Register address
  logic [31:0] wdat = 32'h0, rs = 32'hAF91, m;                // Data, random state, mask
  logic [42:0] ov;                                            // Every output side by side
  int          cyc = 0, tmo = 0, n_fail = 0, n_checks = 0, i;
  adcpc_note_t notes[$];                                      // Expected results, by due cycle
  adcpc_note_t nt;
  string       nm [0:11] = '{"lane1", "lane2", "busy", "par", "frame", "oe", "dlow", "",
                             "dloe", "p3start", "p3pdown", "rdata"};
  adcpc_host_model host (.clk_i(clk), .ser_i(ser), .word_i(~wrd_n), .sel_i(sel),
    .lane_i(lane), .fs_o(fs_w), .bit_one_o(b1_w), .bit_zero_o(b0_w));
  adcpc_pin_ctrl dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(ov[42:11]), .interface_select_i(ser),
    .pin_or_register_mode_i(hws), .word_mode_n_i(wrd_n), .select_or_frame_sync_i(fs_w),
    .read_n_i(rd_n), .start_pair_three_i(st3), .conv_start_i(cnv), .pair_done_i(pd),
    .all_latched_i(al), .cclk_tick_i(tck), .data_bit_one_i(b1_w), .data_bit_zero_i(b0_w),
    .result_low_i(rlow), .serial_out_lane_one_en_o(ov[0]), .serial_out_lane_two_en_o(ov[1]),
    .busy_int_o(ov[2]), .par_active_o(ov[3]), .frame_start_o(ov[4]), .data_oe_o(ov[5]),
    .data_low_o(ov[7:6]), .data_low_oe_o(ov[8]), .pair_three_start_o(ov[9]),
    .pair_three_pdown_o(ov[10]));
  // 4 ns clock
  always #2 clk = ~clk;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  // Note a result due d rising edges from now, kept in due order
  task automatic ex(int lsb, logic [31:0] v, int d);
    adcpc_note_t x;
    int k;
    x = '{cyc + d, lsb, v};
    k = notes.size();
    while (k > 0 && notes[k - 1].due > x.due) k--;
    notes.insert(k, x);
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand one cycle only, then fall back to zero
  task automatic rd_reg(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    ex(RD, e, 1);
    ex(RD, 32'h0, 2);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Monitor: compares the oldest notes once their cycle comes
  always @(negedge clk)
  begin
    while (notes.size() != 0 && notes[0].due <= cyc)
    begin
      nt = notes.pop_front();
      m = (nt.lsb == RD) ? 32'hFFFFFFFF : (nt.lsb == DL) ? 32'h3 : 32'h1;
      check(nm[nt.lsb], 32'(ov >> nt.lsb) & m, nt.v);
    end
    cyc++;
  end
  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk)
  begin
    tmo++;
    if (tmo == 5000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    tk(5);
    rst <= 1'b0;
    for (i = 0; i < 12; i++)
      if (i != 7) ex(i, 32'h0, 1);
    // Serial lanes follow their selects, two cycles behind the lane request
    @(posedge clk);
    ser <= 1'b1;
    repeat (6)
    begin
      @(posedge clk);
      rs = xs(rs);
      lane <= rs[0];
      ex(L2, rs[0], 2);
      ex(L1, 32'h1, 2);
    end
    $display("test lanes done");
    @(posedge clk);
    sel <= 1'b1;
    ex(FS, 32'h1, 2);
    ex(FS, 32'h0, 3);
    ex(PA, 32'h0, 2);
    @(posedge clk);
    sel <= 1'b0;
    tk(3);
    $display("test frame done");
    // Parallel: select, read and word mode gate the data
    @(posedge clk);
    ser <= 1'b0;
    sel <= 1'b1;
    rd_n <= 1'b0;
    rs = xs(rs);
    rlow <= rs[1:0];
    ex(DL, rs[1:0], 1);
    ex(PA, 32'h1, 2);
    ex(OE, 32'h1, 2);
    ex(LO, 32'h1, 2);
    @(posedge clk);
    @(posedge clk);
    rd_n <= 1'b1;
    ex(OE, 32'h0, 1);
    ex(PA, 32'h1, 1);
    @(posedge clk);
    rd_n <= 1'b0;
    wrd_n <= 1'b1;
    ex(OE, 32'h1, 1);
    ex(LO, 32'h0, 1);
    @(posedge clk);
    sel <= 1'b0;
    rd_n <= 1'b1;
    wrd_n <= 1'b0;
    ex(PA, 32'h0, 2);
    ex(OE, 32'h0, 2);
    $display("test parallel done");
    // Busy mode with both polarities
    for (i = 0; i < 2; i++)
    begin
      b = i[0];
      wr_reg(8'h00, {11'h0, b, 20'h0});
      @(posedge clk);
      cnv <= 1'b1;
      ex(BZ, b, 0);
      ex(BZ, !b, 1);
      ex(BZ, !b, 5);
      @(posedge clk);
      cnv <= 1'b0;
      tk(4);
      al <= 1'b1;
      ex(BZ, b, 1);
      @(posedge clk);
      al <= 1'b0;
    end
    $display("test busy done");
    // Sequential: one tick low per finished pair
    wr_reg(8'h00, 32'h00800000);
    @(posedge clk);
    cnv <= 1'b1;
    ex(BZ, 32'h1, 1);
    @(posedge clk);
    cnv <= 1'b0;
    tk(2);
    pd <= 1'b1;
    ex(BZ, 32'h0, 1);
    ex(BZ, 32'h0, 2);
    ex(BZ, 32'h1, 3);
    @(posedge clk);
    pd <= 1'b0;
    @(posedge clk);
    tck <= 1'b1;
    @(posedge clk);
    tck <= 1'b0;
    tk(2);
    al <= 1'b1;
    ex(BZ, 32'h0, 1);
    @(posedge clk);
    al <= 1'b0;
    $display("test sequential done");
    // Interrupt held until a parallel read; register map checks
    wr_reg(8'h00, 32'h00200000);
    wr_reg(8'h08, 32'h00900000);
    rd_reg(8'h00, 32'h00200000);
    rd_reg(8'h08, 32'h0);
    // Earlier conversions left the flag pending: a parallel read clears it first
    @(posedge clk);
    sel <= 1'b1;
    @(posedge clk);
    rd_n <= 1'b0;
    ex(BZ, 32'h0, 1);
    @(posedge clk);
    rd_n <= 1'b1;
    cnv <= 1'b1;
    ex(BZ, 32'h0, 1);
    @(posedge clk);
    cnv <= 1'b0;
    tk(3);
    al <= 1'b1;
    ex(BZ, 32'h1, 1);
    ex(BZ, 32'h1, 5);
    @(posedge clk);
    al <= 1'b0;
    tk(4);
    rd_n <= 1'b0;
    ex(BZ, 32'h0, 1);
    @(posedge clk);
    rd_n <= 1'b1;
    sel <= 1'b0;
    $display("test interrupt done");
    // Pair three start: hardware, refused software, sequential software
    wr_reg(8'h00, 32'h0);
    @(posedge clk);
    st3 <= 1'b1;
    ex(P3, 32'h1, 1);
    ex(P3, 32'h0, 2);
    ex(BZ, 32'h1, 1);
    tk(2);
    st3 <= 1'b0;
    ex(PD, 32'h1, 1);
    // Status mid conversion: converting, raw active, powered down
    rd_reg(8'h04, 32'h0000000B);
    al <= 1'b1;
    @(posedge clk);
    al <= 1'b0;
    hws <= 1'b1;
    @(posedge clk);
    st3 <= 1'b1;
    ex(P3, 32'h0, 1);
    ex(BZ, 32'h0, 1);
    @(posedge clk);
    st3 <= 1'b0;
    wr_reg(8'h00, 32'h00800000);
    @(posedge clk);
    st3 <= 1'b1;
    ex(P3, 32'h1, 1);
    ex(PD, 32'h0, 1);
    tk(3);
    al <= 1'b1;
    ex(BZ, 32'h0, 1);
    @(posedge clk);
    al <= 1'b0;
    st3 <= 1'b0;
    ex(PD, 32'h0, 1);
    $display("test pair three done");
    tk(5);
    finish_test();
  end
endmodule
